// *** rtl/p1ss_pkg.sv ***
/*
 * Constants, field positions and carrier types for the port 1 soft-strap
 * default generator.
 * Assumes a 32-bit APB slave with byte addresses of eight bits.
 */
`default_nettype none

package p1ss_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  OFF_HWCFG = 8'h00;
    localparam logic [7:0]  OFF_BCTL  = 8'h04;
    localparam logic [7:0]  OFF_ADV   = 8'h08;
    localparam logic [7:0]  OFF_MODE  = 8'h0C;
    localparam logic [7:0]  OFF_SCSR  = 8'h10;
    localparam logic [7:0]  OFF_MFC   = 8'h14;
    localparam logic [7:0]  OFF_STAT  = 8'h18;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int HW_AUTOX_BIT  = 0;
    localparam int BC_DUPLEX_BIT = 8;
    localparam int BC_AN_BIT     = 12;
    localparam int BC_SPEED_BIT  = 13;
    localparam int ADV_10HD_BIT  = 5;
    localparam int ADV_10FD_BIT  = 6;
    localparam int ADV_100HD_BIT = 7;
    localparam int ADV_100FD_BIT = 8;
    localparam int ADV_SYM_BIT   = 10;
    localparam int ADV_ASYM_BIT  = 11;
    localparam int MODE_LSB      = 5;
    localparam int SC_CROSS_BIT  = 13;
    localparam int SC_AUTO_BIT   = 14;
    localparam int SC_SEL_BIT    = 15;
    localparam int MFC_RX_BIT    = 0;
    localparam int MFC_TX_BIT    = 1;
    localparam int MFC_BP_BIT    = 2;
    localparam int ST_READY_BIT  = 0;
    localparam int ST_EE_BIT     = 1;
    localparam int ST_STRAP_LSB  = 8;

    // ------------------------------------------------------------------
    // Values.
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_10HD   = 3'h0;
    localparam logic [2:0] MODE_10FD   = 3'h1;
    localparam logic [2:0] MODE_100HD  = 3'h2;
    localparam logic [2:0] MODE_100FD  = 3'h3;
    localparam logic [2:0] MODE_AN_ALL = 3'h7;
    localparam logic       SC_SEL_RESET = 1'h0;
    localparam logic [2:0] SETTLE_CYC   = 3'h5;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IDX_HWCFG, IDX_BCTL, IDX_ADV, IDX_MODE, IDX_SCSR, IDX_MFC,
        IDX_STAT, IDX_NONE
    } p1ss_idx_t;

    typedef enum {P1SS_SETTLE, P1SS_RUN} p1ss_phase_t;

    typedef struct packed {
        logic autox;
        logic mcross;
        logic an;
        logic speed;
        logic duplex;
        logic bp;
        logic fdfc;
    } p1ss_straps_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } p1ss_apb_req_t;

    typedef struct packed {
        logic       hw_autox;
        logic       bc_an;
        logic       bc_speed;
        logic       bc_duplex;
        logic       adv_10hd;
        logic       adv_10fd;
        logic       adv_100hd;
        logic       adv_100fd;
        logic       adv_sym;
        logic       adv_asym;
        logic [2:0] mode;
        logic       sc_sel;
        logic       sc_auto;
        logic       sc_cross;
        logic       mfc_rx;
        logic       mfc_tx;
        logic       mfc_bp;
    } p1ss_regs_t;

endpackage

`default_nettype wire

// *** rtl/p1ss_sync.sv ***
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes an asynchronous pin; the output moves only once the second and
 * third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module p1ss_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } p1ss_sync_state_t;

    p1ss_sync_state_t state_reg;
    p1ss_sync_state_t state_next;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("p1ss_sync: WIDTH must be at least one.");
        end
    end

    // The first stage feeds only the second stage.
    always_comb
    begin
        state_next    = state_reg;
        state_next.s1 = d;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        if (state_reg.s2 == state_reg.s3)
        begin
            state_next.q = state_reg.s3;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.q;

endmodule

`default_nettype wire

// *** rtl/p1ss_top.sv ***
/*
 * Port 1 soft-strap default generator with its APB register file.
 * Assumes a loader that presents override straps with a one-cycle strobe,
 * a one-cycle revert strobe for digital reset or reload without EEPROM,
 * and an asynchronous strap pin shared with an LED.
 */
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Crossover strap sets strap-state bit default.
// - Strap-selected crossover uses both crossover straps.
// - Auto off: manual strap picks straight/crossed.
// - Negotiation strap sets negotiation enable default.
// - Negotiation strap shapes speed, duplex, advert, mode.
// - Speed strap shapes speed, mode, 10M advert.
// - Duplex strap shapes duplex, mode, 10FD advert.
// - Back-pressure strap sets back-pressure enable default.
// - Flow-control strap sets both pause enables.
// - Flow-control strap shapes asymmetric pause advert.
// - Capture at reset release; loader values override.
// - Revert to captured straps without resampling pins.
module p1ss_top #(
    parameter logic MCROSS_TIE = 1'h0,
    parameter logic AN_TIE     = 1'h1,
    parameter logic SPEED_TIE  = 1'h1,
    parameter logic DUPLEX_TIE = 1'h1,
    parameter logic BP_TIE     = 1'h1,
    parameter logic FDFC_TIE   = 1'h1
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire p1ss_pkg::p1ss_apb_req_t apb,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   port1_crossover_led_pin,
    input  wire logic                   ee_load,
    input  wire p1ss_pkg::p1ss_straps_t ee_straps,
    input  wire logic                   straps_revert,
    output var  p1ss_pkg::p1ss_regs_t   cfg,
    output var  logic                   cfg_ready,
    output var  logic                   xover_auto,
    output var  logic                   xover_cross
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        p1ss_pkg::p1ss_phase_t  phase;
        logic [2:0]             settle_cnt;
        p1ss_pkg::p1ss_straps_t latched;
        p1ss_pkg::p1ss_straps_t eff;
        logic                   ee_active;
        p1ss_pkg::p1ss_regs_t   regs;
        logic                   ready;
        logic                   xauto;
        logic                   xcross;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } p1ss_top_state_t;

    p1ss_top_state_t state_reg;
    p1ss_top_state_t state_next;
    logic            pin_sync;

    initial
    begin
        if (p1ss_pkg::ADDR_W != 8)
        begin
            $error("p1ss_top: the register map needs eight address bits.");
        end
    end

    p1ss_sync #(
        .WIDTH (1)
    ) u_pin_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (port1_crossover_led_pin),
        .q    (pin_sync)
    );

    // ------------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------------

    // Maps an APB address onto a register index.
    function automatic p1ss_pkg::p1ss_idx_t reg_index(
        input logic [7:0] addr
    );
        p1ss_pkg::p1ss_idx_t idx;
        case (addr)
            p1ss_pkg::OFF_HWCFG: idx = p1ss_pkg::IDX_HWCFG;
            p1ss_pkg::OFF_BCTL:  idx = p1ss_pkg::IDX_BCTL;
            p1ss_pkg::OFF_ADV:   idx = p1ss_pkg::IDX_ADV;
            p1ss_pkg::OFF_MODE:  idx = p1ss_pkg::IDX_MODE;
            p1ss_pkg::OFF_SCSR:  idx = p1ss_pkg::IDX_SCSR;
            p1ss_pkg::OFF_MFC:   idx = p1ss_pkg::IDX_MFC;
            p1ss_pkg::OFF_STAT:  idx = p1ss_pkg::IDX_STAT;
            default:             idx = p1ss_pkg::IDX_NONE;
        endcase
        return idx;
    endfunction

    // Builds the register reset defaults from a set of straps.
    function automatic p1ss_pkg::p1ss_regs_t strap_defaults(
        input p1ss_pkg::p1ss_straps_t s
    );
        p1ss_pkg::p1ss_regs_t d;
        d           = '0;
        d.hw_autox  = s.autox;
        d.bc_an     = s.an;
        d.bc_speed  = s.an | s.speed;
        d.bc_duplex = s.an | s.duplex;
        d.adv_10hd  = s.an | ~s.speed;
        d.adv_10fd  = s.duplex & (s.an | ~s.speed);
        d.adv_100hd = s.an | s.speed;
        d.adv_100fd = s.duplex & (s.an | s.speed);
        d.adv_sym   = s.fdfc;
        d.adv_asym  = s.fdfc;
        if (s.an)
        begin
            d.mode = p1ss_pkg::MODE_AN_ALL;
        end
        else if (s.speed)
        begin
            d.mode = s.duplex ? p1ss_pkg::MODE_100FD
                              : p1ss_pkg::MODE_100HD;
        end
        else
        begin
            d.mode = s.duplex ? p1ss_pkg::MODE_10FD
                              : p1ss_pkg::MODE_10HD;
        end
        d.sc_sel    = p1ss_pkg::SC_SEL_RESET;
        d.sc_auto   = s.autox;
        d.sc_cross  = s.mcross;
        d.mfc_bp    = s.bp;
        d.mfc_tx    = s.fdfc;
        d.mfc_rx    = s.fdfc;
        return d;
    endfunction

    // Assembles the read word of one register.
    function automatic logic [31:0] read_word(
        input p1ss_pkg::p1ss_idx_t    idx,
        input p1ss_pkg::p1ss_regs_t   r,
        input p1ss_pkg::p1ss_straps_t eff,
        input logic                   ee_active,
        input logic                   ready
    );
        logic [31:0] w;
        w = '0;
        case (idx)
            p1ss_pkg::IDX_HWCFG:
            begin
                w[p1ss_pkg::HW_AUTOX_BIT] = r.hw_autox;
            end
            p1ss_pkg::IDX_BCTL:
            begin
                w[p1ss_pkg::BC_AN_BIT]     = r.bc_an;
                w[p1ss_pkg::BC_SPEED_BIT]  = r.bc_speed;
                w[p1ss_pkg::BC_DUPLEX_BIT] = r.bc_duplex;
            end
            p1ss_pkg::IDX_ADV:
            begin
                w[p1ss_pkg::ADV_10HD_BIT]  = r.adv_10hd;
                w[p1ss_pkg::ADV_10FD_BIT]  = r.adv_10fd;
                w[p1ss_pkg::ADV_100HD_BIT] = r.adv_100hd;
                w[p1ss_pkg::ADV_100FD_BIT] = r.adv_100fd;
                w[p1ss_pkg::ADV_SYM_BIT]   = r.adv_sym;
                w[p1ss_pkg::ADV_ASYM_BIT]  = r.adv_asym;
            end
            p1ss_pkg::IDX_MODE:
            begin
                w[p1ss_pkg::MODE_LSB +: 3] = r.mode;
            end
            p1ss_pkg::IDX_SCSR:
            begin
                w[p1ss_pkg::SC_SEL_BIT]   = r.sc_sel;
                w[p1ss_pkg::SC_AUTO_BIT]  = r.sc_auto;
                w[p1ss_pkg::SC_CROSS_BIT] = r.sc_cross;
            end
            p1ss_pkg::IDX_MFC:
            begin
                w[p1ss_pkg::MFC_RX_BIT] = r.mfc_rx;
                w[p1ss_pkg::MFC_TX_BIT] = r.mfc_tx;
                w[p1ss_pkg::MFC_BP_BIT] = r.mfc_bp;
            end
            p1ss_pkg::IDX_STAT:
            begin
                w[p1ss_pkg::ST_READY_BIT]     = ready;
                w[p1ss_pkg::ST_EE_BIT]        = ee_active;
                w[p1ss_pkg::ST_STRAP_LSB +: 7] = eff;
            end
            default:
            begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb
    begin
        p1ss_pkg::p1ss_idx_t    idx;
        p1ss_pkg::p1ss_straps_t cap;
        logic                   reload;
        idx            = reg_index(apb.paddr);
        cap            = '0;
        reload         = 1'b0;
        state_next     = state_reg;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;

        // Strap capture after reset release, loader override and revert.
        case (state_reg.phase)
            p1ss_pkg::P1SS_SETTLE:
            begin
                if (state_reg.settle_cnt == p1ss_pkg::SETTLE_CYC)
                begin
                    cap.autox  = pin_sync;
                    cap.mcross = MCROSS_TIE;
                    cap.an     = AN_TIE;
                    cap.speed  = SPEED_TIE;
                    cap.duplex = DUPLEX_TIE;
                    cap.bp     = BP_TIE;
                    cap.fdfc   = FDFC_TIE;
                    state_next.latched = cap;
                    state_next.eff     = cap;
                    state_next.phase   = p1ss_pkg::P1SS_RUN;
                    state_next.ready   = 1'b1;
                    reload             = 1'b1;
                end
                else
                begin
                    state_next.settle_cnt = state_reg.settle_cnt + 3'h1;
                end
            end
            p1ss_pkg::P1SS_RUN:
            begin
                if (ee_load)
                begin
                    state_next.eff       = ee_straps;
                    state_next.ee_active = 1'b1;
                    reload               = 1'b1;
                end
                else if (straps_revert)
                begin
                    state_next.eff       = state_reg.latched;
                    state_next.ee_active = 1'b0;
                    reload               = 1'b1;
                end
            end
            default:
            begin
                state_next.phase = p1ss_pkg::P1SS_SETTLE;
            end
        endcase

        // Straps only seed the registers; writes change them later.
        if (reload)
        begin
            state_next.regs = strap_defaults(state_next.eff);
        end

        // APB access phase: one wait state, then the answer.
        if (apb.psel && apb.penable && !state_reg.pready)
        begin
            state_next.pready  = 1'b1;
            state_next.pslverr = (idx == p1ss_pkg::IDX_NONE);
            state_next.prdata  = apb.pwrite ? 32'h0000_0000
                : read_word(idx, state_reg.regs, state_reg.eff,
                            state_reg.ee_active, state_reg.ready);
        end

        if (apb.psel && apb.penable && state_reg.pready && apb.pwrite
            && !reload)
        begin
            case (idx)
                p1ss_pkg::IDX_HWCFG:
                begin
                    state_next.regs.hw_autox =
                        apb.pwdata[p1ss_pkg::HW_AUTOX_BIT];
                end
                p1ss_pkg::IDX_BCTL:
                begin
                    state_next.regs.bc_an =
                        apb.pwdata[p1ss_pkg::BC_AN_BIT];
                    state_next.regs.bc_speed =
                        apb.pwdata[p1ss_pkg::BC_SPEED_BIT];
                    state_next.regs.bc_duplex =
                        apb.pwdata[p1ss_pkg::BC_DUPLEX_BIT];
                end
                p1ss_pkg::IDX_ADV:
                begin
                    state_next.regs.adv_10hd =
                        apb.pwdata[p1ss_pkg::ADV_10HD_BIT];
                    state_next.regs.adv_10fd =
                        apb.pwdata[p1ss_pkg::ADV_10FD_BIT];
                    state_next.regs.adv_100hd =
                        apb.pwdata[p1ss_pkg::ADV_100HD_BIT];
                    state_next.regs.adv_100fd =
                        apb.pwdata[p1ss_pkg::ADV_100FD_BIT];
                    state_next.regs.adv_sym =
                        apb.pwdata[p1ss_pkg::ADV_SYM_BIT];
                    state_next.regs.adv_asym =
                        apb.pwdata[p1ss_pkg::ADV_ASYM_BIT];
                end
                p1ss_pkg::IDX_MODE:
                begin
                    state_next.regs.mode =
                        apb.pwdata[p1ss_pkg::MODE_LSB +: 3];
                end
                p1ss_pkg::IDX_SCSR:
                begin
                    state_next.regs.sc_sel =
                        apb.pwdata[p1ss_pkg::SC_SEL_BIT];
                    state_next.regs.sc_auto =
                        apb.pwdata[p1ss_pkg::SC_AUTO_BIT];
                    state_next.regs.sc_cross =
                        apb.pwdata[p1ss_pkg::SC_CROSS_BIT];
                end
                p1ss_pkg::IDX_MFC:
                begin
                    state_next.regs.mfc_rx =
                        apb.pwdata[p1ss_pkg::MFC_RX_BIT];
                    state_next.regs.mfc_tx =
                        apb.pwdata[p1ss_pkg::MFC_TX_BIT];
                    state_next.regs.mfc_bp =
                        apb.pwdata[p1ss_pkg::MFC_BP_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Crossover: straps rule while the select bit is clear.
        if (!state_next.regs.sc_sel)
        begin
            state_next.xauto  = state_next.eff.autox;
            state_next.xcross = !state_next.eff.autox
                                && state_next.eff.mcross;
        end
        else
        begin
            state_next.xauto  = state_next.regs.sc_auto;
            state_next.xcross = !state_next.regs.sc_auto
                                && state_next.regs.sc_cross;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg       <= '0;
            state_reg.phase <= p1ss_pkg::P1SS_SETTLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata      = state_reg.prdata;
    assign pready      = state_reg.pready;
    assign pslverr     = state_reg.pslverr;
    assign cfg         = state_reg.regs;
    assign cfg_ready   = state_reg.ready;
    assign xover_auto  = state_reg.xauto;
    assign xover_cross = state_reg.xcross;

endmodule

`default_nettype wire

// *** tb/p1ss_strap_src.sv ***
/* Board strap pin and loader model for port 1.
   Assumes its tasks are called right after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module p1ss_strap_src (
    input  wire logic                   clk,
    output var  logic                   pin,
    output var  logic                   ee_load,
    output var  p1ss_pkg::p1ss_straps_t ee_straps,
    output var  logic                   straps_revert
);
    initial
    begin
        pin = 1'h1;
        ee_load = 1'h0;
        ee_straps = 7'h00;
        straps_revert = 1'h0;
    end
    task automatic set_pin(input logic v);
        pin <= v;
    endtask
    // Strap data is scrambled outside the strobe so stale values never pass.
    task automatic load(input p1ss_pkg::p1ss_straps_t s);
        ee_load <= 1'h1;
        ee_straps <= s;
        @(posedge clk);
        ee_load <= 1'h0;
        ee_straps <= ~s;
    endtask
    task automatic revert();
        straps_revert <= 1'h1;
        @(posedge clk);
        straps_revert <= 1'h0;
    endtask
endmodule
`default_nettype wire

// *** tb/p1ss_top_monitor.sv ***
/* Assertions on the port 1 strap default block.
   Assumes p1ss_top with its default tie-off parameters. */
`timescale 1ns/1ps
`default_nettype none
module p1ss_top_monitor (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire p1ss_pkg::p1ss_apb_req_t apb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    port1_crossover_led_pin,
    input wire logic                    ee_load,
    input wire p1ss_pkg::p1ss_straps_t  ee_straps,
    input wire logic                    straps_revert,
    input wire p1ss_pkg::p1ss_regs_t    cfg,
    input wire logic                    cfg_ready,
    input wire logic                    xover_auto,
    input wire logic                    xover_cross
);
    // Pin level as it stood when the straps were captured.
    logic cap_pin;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            cap_pin <= 1'h0;
        else if (!cfg_ready)
            cap_pin <= port1_crossover_led_pin;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    cap_autox_a: assert property
        ($rose(cfg_ready) |-> cfg.hw_autox == port1_crossover_led_pin)
        else $error("strap state bit differs from pin");
    cap_ties_a: assert property
        ($rose(cfg_ready) |-> cfg.bc_an && cfg.mfc_bp && cfg.mode == 3'h7)
        else $error("tied strap defaults wrong");
    ld_cross_a: assert property
        (ee_load && cfg_ready |=> xover_auto == $past(ee_straps.autox)
         && xover_cross == (!$past(ee_straps.autox) && $past(ee_straps.mcross)))
        else $error("crossover not from loaded straps");
    ld_pause_a: assert property
        (ee_load && cfg_ready |=> cfg.mfc_tx == $past(ee_straps.fdfc)
         && cfg.mfc_rx == cfg.mfc_tx && cfg.adv_asym == cfg.mfc_tx)
        else $error("pause defaults wrong");
    ld_mode_a: assert property
        (ee_load && cfg_ready |=> cfg.mode == ($past(ee_straps.an) ? 3'h7 :
         {1'h0, $past(ee_straps.speed), $past(ee_straps.duplex)}))
        else $error("mode default wrong");
    revert_pin_a: assert property
        (straps_revert && !ee_load && cfg_ready |=> cfg.hw_autox == cap_pin
         && xover_auto == cap_pin)
        else $error("revert did not restore captured pin");
    wr_ctl_a: assert property
        (apb.psel && apb.penable && apb.pwrite && pready && cfg_ready
         && apb.paddr == p1ss_pkg::OFF_BCTL && !ee_load && !straps_revert
         |=> cfg.bc_an == $past(apb.pwdata[p1ss_pkg::BC_AN_BIT]))
        else $error("software write lost");
    apb_wait_a: assert property
        (apb.psel && apb.penable && !pready |=> pready ##1 !pready)
        else $error("answer timing wrong");
    bad_addr_a: assert property
        (pready && apb.paddr > p1ss_pkg::OFF_STAT |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    cover property (ee_load && cfg_ready);
    cover property (straps_revert && cfg_ready);
    cover property (pslverr);
endmodule
bind p1ss_top p1ss_top_monitor u_mon (.clk(clk), .rstn(rstn), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port1_crossover_led_pin(port1_crossover_led_pin),
    .ee_load(ee_load), .ee_straps(ee_straps),
    .straps_revert(straps_revert), .cfg(cfg), .cfg_ready(cfg_ready),
    .xover_auto(xover_auto), .xover_cross(xover_cross));
`default_nettype wire

// *** tb/testbench.sv ***
/* Self-checking bench for the port 1 strap default block.
   Assumes default tie-offs; the APB master waits for pready. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                    clk = 1'h0;
    logic                    rstn;
    p1ss_pkg::p1ss_apb_req_t apb;
    logic [31:0]             prdata;
    logic                    pready, pslverr, pin, ee_load, straps_revert;
    logic                    cfg_ready, xover_auto, xover_cross;
    p1ss_pkg::p1ss_straps_t  ee_straps;
    int                      n_fail = 0;
    int                      checks = 0;
    always #4 clk = ~clk;
    p1ss_top uut (.clk(clk), .rstn(rstn), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port1_crossover_led_pin(pin),
        .ee_load(ee_load), .ee_straps(ee_straps), .cfg(),
        .straps_revert(straps_revert), .cfg_ready(cfg_ready),
        .xover_auto(xover_auto), .xover_cross(xover_cross));
    p1ss_strap_src src (.clk(clk), .pin(pin), .ee_load(ee_load),
        .ee_straps(ee_straps), .straps_revert(straps_revert));
    task automatic conclude();
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        apb <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        apb.psel <= 1'h0;
        apb.penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'h0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'h1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic t_capture(input logic ax);
        while (cfg_ready !== 1'h1)
            @(posedge clk);
        rd(p1ss_pkg::OFF_HWCFG, {31'h0, ax});
        rd(p1ss_pkg::OFF_BCTL, 32'h3100);
        rd(p1ss_pkg::OFF_ADV, 32'hDE0);
        rd(p1ss_pkg::OFF_MODE, 32'hE0);
        rd(p1ss_pkg::OFF_SCSR, {17'h0, ax, 14'h0});
        rd(p1ss_pkg::OFF_MFC, 32'h7);
        chk({30'h0, xover_auto, xover_cross}, {30'h0, ax, 1'h0});
    endtask
    task automatic t_load(input p1ss_pkg::p1ss_straps_t s, input logic hw,
        input logic [31:0] bc, adv, md, mfc, xo);
        src.load(s);
        rd(p1ss_pkg::OFF_HWCFG, {31'h0, hw});
        rd(p1ss_pkg::OFF_BCTL, bc);
        rd(p1ss_pkg::OFF_ADV, adv);
        rd(p1ss_pkg::OFF_MODE, md);
        rd(p1ss_pkg::OFF_MFC, mfc);
        rd(p1ss_pkg::OFF_STAT, {17'h0, s, 8'h03});
        chk({30'h0, xover_auto, xover_cross}, xo);
    endtask
    task automatic t_revert();
        src.set_pin(1'h0);
        src.revert();
        rd(p1ss_pkg::OFF_HWCFG, 32'h1);
        rd(p1ss_pkg::OFF_BCTL, 32'h3100);
        rd(p1ss_pkg::OFF_STAT, 32'h5F01);
    endtask
    task automatic t_write();
        logic [31:0] r;
        logic e;
        wr(p1ss_pkg::OFF_BCTL, 32'h0);
        rd(p1ss_pkg::OFF_BCTL, 32'h0);
        wr(p1ss_pkg::OFF_MFC, 32'h4);
        rd(p1ss_pkg::OFF_MFC, 32'h4);
        wr(p1ss_pkg::OFF_SCSR, 32'hA000);
        rd(p1ss_pkg::OFF_SCSR, 32'hA000);
        chk({30'h0, xover_auto, xover_cross}, 32'h1);
        xfer(1'h0, 8'h40, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
    endtask
    initial
    begin
        rstn = 1'h0;
        apb = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        t_capture(1'h1);
        t_load(7'h24, 1'h0, 32'h100, 32'h60, 32'h20, 32'h0, 32'h1);
        t_load(7'h4B, 1'h1, 32'h2000, 32'hC80, 32'h40, 32'h7, 32'h2);
        t_revert();
        t_write();
        rstn <= 1'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        t_capture(1'h0);
        conclude();
    end
    initial
    begin
        #100000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
